// ===== hw/aurt_regs.svh
// register offsets, field positions, reset values and counts
`ifndef AURT_REGS_SVH
`define AURT_REGS_SVH
`define AURT_OFS_BAUD_CTL 8'h00
`define AURT_OFS_RX_STAT 8'h04
`define AURT_OFS_DIV_LOW 8'h08
`define AURT_OFS_DIV_HIGH 8'h0c
`define AURT_OFS_TX_HOLD 8'h10
`define AURT_OFS_TX_STAT 8'h14
`define AURT_OFS_RX_DATA 8'h18
`define AURT_OFS_IRQ_CTL 8'h1c
// baud_control bits
`define AURT_B_RX_IDLE 6
`define AURT_B_RX_POL 5
`define AURT_B_TX_POL 4
`define AURT_B_WIDE_DIV 3
// receive_status_control bits
`define AURT_B_SERIAL_PORT_ENABLE 7
`define AURT_B_RX9 6
`define AURT_B_SREN 5
`define AURT_B_CONTINUOUS_RECEIVE_ENABLE 4
`define AURT_B_ADDRESS_DETECT_ENABLE 3
`define AURT_B_FRAMING_ERROR 2
`define AURT_B_OVERRUN_ERROR 1
`define AURT_B_RECEIVE_NINTH_BIT 0
// transmit_status_control bits
`define AURT_B_CSRC 7
`define AURT_B_TX9 6
`define AURT_B_TRANSMIT_ENABLE 5
`define AURT_B_CLKMODE 4
`define AURT_B_SENDB 3
`define AURT_B_HSPEED 2
`define AURT_B_TRMT 1
`define AURT_B_TRANSMIT_NINTH_BIT 0
// irq control bits
`define AURT_B_GIE 0
`define AURT_B_PERIPHERAL_IRQ_ENABLE 1
`define AURT_B_RCIE 2
`define AURT_B_TXIE 3
`define AURT_B_RCIF 4
`define AURT_B_TXIF 5
`define AURT_RST_BYTE 8'h00
`define AURT_OVERSAMPLE 16
`define AURT_HALF_BIT 4'h7
`define AURT_FULL_BIT 4'hf
`define AURT_FIFO_DEPTH 2
`endif

// ===== hw/aurt_pkg.sv
// types shared by the serial port
package aurt_pkg;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} aurt_rx_e;
   typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} aurt_tx_e;
   typedef logic [7:0] aurt_byte_t;
   typedef logic [7:0] aurt_addr_t;
endpackage

// ===== hw/aurt_core.sv
// async serial port: receiver, receive buffer, transmitter, apb registers
//
// Decided for this implementation: the register offsets and register access over APB.
`include "aurt_regs.svh"
module aurt_core #(
   parameter int DIV_W = 16
) (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire aurt_pkg::aurt_addr_t paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped
   input wire logic receive_pin, // serial input
   output logic transmit_pin_o, // serial output level
   output logic transmit_pin_oe, // serial output enable
   output logic irq // interrupt request
);
   import aurt_pkg::*;

   // ---------------------------------------------
   // register file
   // ---------------------------------------------
   aurt_byte_t baud_control, next_baud_control;
   aurt_byte_t rx_ctl, next_rx_ctl;
   aurt_byte_t div_low, next_div_low;
   aurt_byte_t div_high, next_div_high;
   aurt_byte_t tx_ctl, next_tx_ctl;
   logic [3:0] irq_ctl, next_irq_ctl;
   logic [31:0] next_prdata;
   logic next_pslverr;
   logic setup, acc_wr, acc_rd, hit, wr_hold, rd_data;
   logic serial_port_enable, continuous_receive_enable, clk_mode, transmit_enable, rx_on, tx_on, rx9, tx9, address_detect_enable;
   logic rx_flag, tx_flag, framing_error_top, receive_ninth_bit_top, overrun_error, tx_busy, hold_full;
   logic rx_idle_st;
   aurt_byte_t top_data;

   assign setup = psel & ~penable;
   assign acc_wr = psel & penable & pwrite;
   assign acc_rd = psel & penable & ~pwrite;
   assign hit = (paddr[1:0] == 2'h0) && (paddr <= `AURT_OFS_IRQ_CTL);
   assign wr_hold = acc_wr && paddr == `AURT_OFS_TX_HOLD;
   assign rd_data = acc_rd && paddr == `AURT_OFS_RX_DATA;
   assign pready = 1'b1;
   assign serial_port_enable = rx_ctl[`AURT_B_SERIAL_PORT_ENABLE];
   assign continuous_receive_enable = rx_ctl[`AURT_B_CONTINUOUS_RECEIVE_ENABLE];
   assign rx9 = rx_ctl[`AURT_B_RX9];
   assign address_detect_enable = rx_ctl[`AURT_B_ADDRESS_DETECT_ENABLE];
   assign clk_mode = tx_ctl[`AURT_B_CLKMODE];
   assign transmit_enable = tx_ctl[`AURT_B_TRANSMIT_ENABLE];
   assign tx9 = tx_ctl[`AURT_B_TX9];
   assign rx_on = continuous_receive_enable & ~clk_mode & serial_port_enable;
   assign tx_on = transmit_enable & ~clk_mode & serial_port_enable;
   assign tx_flag = tx_on & ~hold_full;
   assign irq = irq_ctl[`AURT_B_GIE] & irq_ctl[`AURT_B_PERIPHERAL_IRQ_ENABLE]
      & ((irq_ctl[`AURT_B_TXIE] & tx_flag)
      | (irq_ctl[`AURT_B_RCIE] & rx_flag));

   always_comb begin
      next_baud_control = baud_control;
      next_rx_ctl = rx_ctl;
      next_div_low = div_low;
      next_div_high = div_high;
      next_tx_ctl = tx_ctl;
      next_irq_ctl = irq_ctl;
      next_prdata = prdata;
      next_pslverr = pslverr;
      if (acc_wr) begin
         case (paddr)
            `AURT_OFS_BAUD_CTL: next_baud_control = pwdata[7:0] & 8'h38;
            `AURT_OFS_RX_STAT: next_rx_ctl = pwdata[7:0] & 8'hf8;
            `AURT_OFS_DIV_LOW: next_div_low = pwdata[7:0];
            `AURT_OFS_DIV_HIGH: next_div_high = pwdata[7:0];
            `AURT_OFS_TX_STAT: next_tx_ctl = pwdata[7:0] & 8'hfd;
            `AURT_OFS_IRQ_CTL: next_irq_ctl = pwdata[3:0];
            default: next_irq_ctl = irq_ctl;
         endcase
      end
      if (setup) begin
         next_pslverr = ~hit;
         next_prdata = 32'h0;
         case (paddr)
            `AURT_OFS_BAUD_CTL: begin
               next_prdata[7:0] = baud_control;
               next_prdata[`AURT_B_RX_IDLE] = rx_idle_st;
            end
            `AURT_OFS_RX_STAT: begin
               next_prdata[7:0] = rx_ctl;
               next_prdata[`AURT_B_FRAMING_ERROR] = framing_error_top;
               next_prdata[`AURT_B_OVERRUN_ERROR] = overrun_error;
               next_prdata[`AURT_B_RECEIVE_NINTH_BIT] = receive_ninth_bit_top;
            end
            `AURT_OFS_DIV_LOW: next_prdata[7:0] = div_low;
            `AURT_OFS_DIV_HIGH: next_prdata[7:0] = div_high;
            `AURT_OFS_TX_STAT: begin
               next_prdata[7:0] = tx_ctl;
               next_prdata[`AURT_B_TRMT] = ~tx_busy;
            end
            `AURT_OFS_RX_DATA: next_prdata[7:0] = top_data;
            `AURT_OFS_IRQ_CTL: begin
               next_prdata[3:0] = irq_ctl;
               next_prdata[`AURT_B_RCIF] = rx_flag;
               next_prdata[`AURT_B_TXIF] = tx_flag;
            end
            default: next_prdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         baud_control <= `AURT_RST_BYTE;
         rx_ctl <= `AURT_RST_BYTE;
         div_low <= `AURT_RST_BYTE;
         div_high <= `AURT_RST_BYTE;
         tx_ctl <= `AURT_RST_BYTE;
         irq_ctl <= 4'h0;
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         baud_control <= next_baud_control;
         rx_ctl <= next_rx_ctl;
         div_low <= next_div_low;
         div_high <= next_div_high;
         tx_ctl <= next_tx_ctl;
         irq_ctl <= next_irq_ctl;
         prdata <= next_prdata;
         pslverr <= next_pslverr;
      end
   end

   // ---------------------------------------------
   // baud tick at sixteen times the bit rate
   // ---------------------------------------------
   logic [DIV_W-1:0] bcnt, next_bcnt;
   logic tick;
   assign tick = serial_port_enable && bcnt == DIV_W'({div_high, div_low});
   always_comb begin
      next_bcnt = bcnt + DIV_W'(1);
      if (!serial_port_enable || tick) next_bcnt = '0;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) bcnt <= '0;
      else bcnt <= next_bcnt;
   end

   // ---------------------------------------------
   // transmitter
   // ---------------------------------------------
   aurt_tx_e tx_st, next_tx_st;
   logic [8:0] hold, next_hold, tsr, next_tsr;
   logic next_hold_full, tline, next_tline;
   logic [3:0] ttk, next_ttk, tbit, next_tbit;
   assign tx_busy = tx_st != TX_IDLE;
   assign transmit_pin_o = tline ^ baud_control[`AURT_B_TX_POL];
   assign transmit_pin_oe = serial_port_enable & transmit_enable;
   always_comb begin
      next_tx_st = tx_st;
      next_hold = hold;
      next_hold_full = hold_full;
      next_tsr = tsr;
      next_ttk = ttk;
      next_tbit = tbit;
      next_tline = tline;
      if (wr_hold && tx_on) begin
         // ninth bit captured with the byte
         next_hold = {tx_ctl[`AURT_B_TRANSMIT_NINTH_BIT], pwdata[7:0]};
         next_hold_full = 1'b1;
      end
      if (tick) next_ttk = ttk + 4'h1;
      case (tx_st)
         TX_IDLE: begin
            next_tline = 1'b1;
            if (hold_full && tx_on) begin
               next_tsr = hold;
               next_hold_full = 1'b0;
               next_tx_st = TX_START;
               next_ttk = 4'h0;
               next_tline = 1'b0;
            end
         end
         TX_START:
            if (tick && ttk == `AURT_FULL_BIT) begin
               next_tx_st = TX_DATA;
               next_tbit = 4'h0;
               next_tline = tsr[0];
            end
         TX_DATA:
            if (tick && ttk == `AURT_FULL_BIT) begin
               next_tsr = {1'b0, tsr[8:1]};
               next_tbit = tbit + 4'h1;
               next_tline = tsr[1];
               if (tbit == (tx9 ? 4'h8 : 4'h7)) begin
                  next_tx_st = TX_STOP;
                  next_tline = 1'b1;
               end
            end
         TX_STOP:
            if (tick && ttk == `AURT_FULL_BIT) next_tx_st = TX_IDLE;
         default: next_tx_st = TX_IDLE;
      endcase
      if (!tx_on) begin
         next_tx_st = TX_IDLE;
         next_hold_full = 1'b0;
         next_tline = 1'b1;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_st <= TX_IDLE;
         hold <= 9'h0;
         hold_full <= 1'b0;
         tsr <= 9'h0;
         ttk <= 4'h0;
         tbit <= 4'h0;
         tline <= 1'b1;
      end else begin
         tx_st <= next_tx_st;
         hold <= next_hold;
         hold_full <= next_hold_full;
         tsr <= next_tsr;
         ttk <= next_ttk;
         tbit <= next_tbit;
         tline <= next_tline;
      end
   end

   // ---------------------------------------------
   // receiver and two-entry buffer
   // ---------------------------------------------
   aurt_rx_e rx_st, next_rx_st;
   logic [8:0] receive_shift_reg, next_rsr;
   logic [3:0] rtk, next_rtk, rbit, next_rbit;
   logic [2:0] hist, next_hist;
   logic lvl, lvl_d, maj, push, pop, next_overrun_error;
   logic [9:0] mem [`AURT_FIFO_DEPTH];
   logic [9:0] entry;
   logic wptr, rptr, next_wptr, next_rptr;
   logic [1:0] cnt, next_cnt;
   assign lvl = receive_pin ^ baud_control[`AURT_B_RX_POL];
   assign next_hist = {hist[1:0], lvl};
   assign maj = (next_hist[0] & next_hist[1]) | (next_hist[1] & next_hist[2])
      | (next_hist[0] & next_hist[2]);
   assign rx_idle_st = rx_st == RX_IDLE;
   assign pop = rd_data && cnt != 2'h0;
   assign rx_flag = rx_on && cnt != 2'h0;
   assign top_data = mem[rptr][7:0];
   assign framing_error_top = cnt != 2'h0 && mem[rptr][9];
   assign receive_ninth_bit_top = cnt != 2'h0 && mem[rptr][8];
   assign entry = rx9 ? {~maj, receive_shift_reg} : {~maj, 1'b0, receive_shift_reg[8:1]};

   always_comb begin
      next_rx_st = rx_st;
      next_rsr = receive_shift_reg;
      next_rtk = rtk;
      next_rbit = rbit;
      next_overrun_error = overrun_error;
      push = 1'b0;
      if (tick) next_rtk = rtk + 4'h1;
      case (rx_st)
         RX_IDLE:
            if (rx_on && !overrun_error && lvl_d && !lvl) begin
               next_rx_st = RX_START;
               next_rtk = 4'h0;
            end
         RX_START:
            if (tick && rtk == `AURT_HALF_BIT) begin
               next_rtk = 4'h0;
               next_rbit = 4'h0;
               next_rx_st = maj ? RX_IDLE : RX_DATA;
            end
         RX_DATA:
            if (tick && rtk == `AURT_FULL_BIT) begin
               next_rsr = {maj, receive_shift_reg[8:1]};
               next_rbit = rbit + 4'h1;
               if (rbit == (rx9 ? 4'h8 : 4'h7)) next_rx_st = RX_STOP;
            end
         RX_STOP:
            if (tick && rtk == `AURT_FULL_BIT) begin
               next_rx_st = RX_IDLE;
               if (!address_detect_enable || !rx9 || entry[8]) begin
                  if (cnt == 2'h2 && !pop) next_overrun_error = 1'b1;
                  else push = 1'b1;
               end
            end
         default: next_rx_st = RX_IDLE;
      endcase
      if (!rx_on) begin
         next_rx_st = RX_IDLE;
         next_overrun_error = 1'b0;
         push = 1'b0;
      end
      next_wptr = wptr ^ push;
      next_rptr = rptr ^ pop;
      next_cnt = cnt + {1'b0, push} - {1'b0, pop};
      if (!serial_port_enable) begin
         next_wptr = 1'b0;
         next_rptr = 1'b0;
         next_cnt = 2'h0;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_st <= RX_IDLE;
         receive_shift_reg <= 9'h0;
         rtk <= 4'h0;
         rbit <= 4'h0;
         hist <= 3'h7;
         lvl_d <= 1'b1;
         overrun_error <= 1'b0;
         wptr <= 1'b0;
         rptr <= 1'b0;
         cnt <= 2'h0;
         mem[0] <= 10'h0;
         mem[1] <= 10'h0;
      end else begin
         rx_st <= next_rx_st;
         receive_shift_reg <= next_rsr;
         rtk <= next_rtk;
         rbit <= next_rbit;
         if (tick) hist <= next_hist;
         lvl_d <= lvl;
         overrun_error <= next_overrun_error;
         wptr <= next_wptr;
         rptr <= next_rptr;
         cnt <= next_cnt;
         if (push) mem[wptr] <= entry;
      end
   end

   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   AST_TXIF_ON_ENABLE: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(transmit_enable) && serial_port_enable && !clk_mode |-> tx_flag)
      else $error("transmit flag not set on enable");
   AST_TX_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
      irq_ctl == 4'hb && tx_flag |-> irq)
      else $error("transmit interrupt missing");
   AST_RX_IRQ_GATED: assert property (@(posedge pclk) disable iff (!presetn)
      irq |-> irq_ctl[0] && irq_ctl[1] && (tx_flag || rx_flag))
      else $error("interrupt without enables");
   AST_TX_STARTS: assert property (@(posedge pclk) disable iff (!presetn)
      wr_hold && tx_on && !tx_busy && !hold_full ##1 tx_on
      |-> ##1 tx_st == TX_START && !tline)
      else $error("transmission did not start");
   AST_BUF_LIMIT: assert property (@(posedge pclk) disable iff (!presetn)
      cnt <= 2'h2)
      else $error("buffer count above two");
   AST_ABORT_START: assert property (@(posedge pclk) disable iff (!presetn)
      rx_st == RX_START && tick && rtk == `AURT_HALF_BIT && maj
      |=> rx_st == RX_IDLE && $stable(overrun_error))
      else $error("false start not abandoned");
   AST_STOP_PUSH: assert property (@(posedge pclk) disable iff (!presetn)
      rx_on && rx_st == RX_STOP && tick && rtk == `AURT_FULL_BIT
      && cnt < 2'h2 && !pop && !address_detect_enable ##1 rx_on
      |-> cnt == $past(cnt) + 2'h1 && rx_flag)
      else $error("character not buffered after stop");
   AST_OVERRUN_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      overrun_error && rx_on && rx_st == RX_IDLE |=> rx_st == RX_IDLE)
      else $error("reception during overrun");
   AST_OVERRUN_ERROR_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
      !continuous_receive_enable |=> !overrun_error)
      else $error("overrun not cleared by disable");
   AST_PORT_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      !serial_port_enable |=> cnt == 2'h0 && rx_st == RX_IDLE && !framing_error_top)
      else $error("port disable did not flush receiver");
endmodule // aurt_core

// ===== sim/aurt_peer.sv
// remote serial peer: sends frames to the block and catches its frames
module aurt_peer #(
   parameter int BIT_CYC = 16
) (
   input wire logic pclk, // system clock
   input wire logic inv, // line inversion
   input wire logic line_in, // line from the block
   output logic line_out // line to the block
);
   timeunit 1ns;
   timeprecision 1ps;
   logic lvl;
   initial lvl = 1'b1;
   assign line_out = lvl ^ inv;
   // ------------------------------
   // sending side
   // ------------------------------
   task automatic send(input logic [8:0] d, input int nb, input logic stp);
      for (int i = 0; i < nb + 2; i++) begin
         if (i == 0) begin
            lvl <= 1'b0;
         end else if (i <= nb) begin
            lvl <= d[i-1];
         end else begin
            lvl <= stp;
         end
         repeat (BIT_CYC) @(posedge pclk);
      end
      lvl <= 1'b1;
      repeat (4) @(posedge pclk);
   endtask
   // short low pulse, too short for a start bit
   task automatic glitch(input int n);
      lvl <= 1'b0;
      repeat (n) @(posedge pclk);
      lvl <= 1'b1;
      repeat (2 * BIT_CYC) @(posedge pclk);
   endtask
   // ------------------------------
   // catching side
   // ------------------------------
   task automatic catch(input int nb, output logic [8:0] d, output logic ok);
      int n;
      d = '0;
      ok = 1'b0;
      n = 0;
      while (line_in !== 1'b0 && n < 400) begin
         @(posedge pclk);
         n++;
      end
      repeat (BIT_CYC / 2) @(posedge pclk);
      if (line_in !== 1'b0) return;
      for (int i = 0; i < nb; i++) begin
         repeat (BIT_CYC) @(posedge pclk);
         d[i] = line_in;
      end
      repeat (BIT_CYC) @(posedge pclk);
      ok = (line_in === 1'b1);
   endtask
endmodule // aurt_peer

// ===== sim/tb_top.sv
// self-checking bench of the serial port
`include "aurt_regs.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, rx_inv, rx_line;
   logic tx_o, tx_oe, irq, pready, pslverr;
   aurt_pkg::aurt_addr_t paddr;
   logic [31:0] pwdata, prdata;
   int err_count, checks, cyc;
   aurt_core dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .receive_pin(rx_line), .transmit_pin_o(tx_o),
      .transmit_pin_oe(tx_oe), .irq(irq));
   aurt_peer peer (.pclk(pclk), .inv(rx_inv), .line_in(tx_o),
      .line_out(rx_line));
   always #10 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 30000) begin
         err_count++;
         summarize();
      end
   end
   // ------------------------------
   // shared tasks
   // ------------------------------
   task automatic summarize;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic xfer(input logic w, input aurt_pkg::aurt_addr_t a,
         input logic [31:0] d, output logic [31:0] q, output logic e);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input aurt_pkg::aurt_addr_t a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      xfer(1'b1, a, d, q, e);
   endtask
   task automatic rd(input aurt_pkg::aurt_addr_t a, input logic [31:0] x);
      logic [31:0] q;
      logic e;
      xfer(1'b0, a, 32'h0, q, e);
      check(q, x);
   endtask
   // ------------------------------
   // scenarios
   // ------------------------------
   task automatic t_reset;
      logic [31:0] q;
      logic e;
      rd(`AURT_OFS_IRQ_CTL, 32'h0);
      rd(`AURT_OFS_RX_STAT, 32'h0);
      rd(`AURT_OFS_BAUD_CTL, 32'h40);
      check({31'h0, tx_oe}, 32'h0);
      xfer(1'b0, 8'h20, 32'h0, q, e);
      check({31'h0, e}, 32'h1);
      rd(`AURT_OFS_TX_HOLD, 32'h0);
      wr(`AURT_OFS_DIV_LOW, 32'h5a);
      rd(`AURT_OFS_DIV_LOW, 32'h5a);
      wr(`AURT_OFS_DIV_LOW, 32'h0);
      $display("done: reset and map");
   endtask
   task automatic t_enable;
      wr(`AURT_OFS_RX_STAT, 32'h80);
      peer.send(9'h055, 8, 1'b1);
      wr(`AURT_OFS_RX_STAT, 32'h10);
      peer.send(9'h055, 8, 1'b1);
      rd(`AURT_OFS_IRQ_CTL, 32'h0);
      wr(`AURT_OFS_RX_STAT, 32'h90);
      peer.glitch(4);
      rd(`AURT_OFS_IRQ_CTL, 32'h0);
      peer.send(9'h0a5, 8, 1'b1);
      rd(`AURT_OFS_IRQ_CTL, 32'h10);
      rd(`AURT_OFS_RX_DATA, 32'ha5);
      rd(`AURT_OFS_IRQ_CTL, 32'h0);
      wr(`AURT_OFS_IRQ_CTL, 32'h07);
      peer.send(9'h03c, 8, 1'b1);
      check({31'h0, irq}, 32'h1);
      wr(`AURT_OFS_IRQ_CTL, 32'h03);
      check({31'h0, irq}, 32'h0);
      rd(`AURT_OFS_IRQ_CTL, 32'h13);
      rd(`AURT_OFS_RX_DATA, 32'h3c);
      wr(`AURT_OFS_IRQ_CTL, 32'h0);
      $display("done: enable, glitch, interrupt");
   endtask
   task automatic t_overrun;
      peer.send(9'h011, 8, 1'b1);
      peer.send(9'h022, 8, 1'b1);
      rd(`AURT_OFS_RX_STAT, 32'h90);
      peer.send(9'h033, 8, 1'b1);
      rd(`AURT_OFS_RX_STAT, 32'h92);
      peer.send(9'h044, 8, 1'b1);
      rd(`AURT_OFS_RX_DATA, 32'h11);
      rd(`AURT_OFS_RX_DATA, 32'h22);
      rd(`AURT_OFS_IRQ_CTL, 32'h0);
      wr(`AURT_OFS_RX_STAT, 32'h80);
      rd(`AURT_OFS_RX_STAT, 32'h80);
      wr(`AURT_OFS_RX_STAT, 32'h90);
      $display("done: overrun");
   endtask
   task automatic t_frame;
      peer.send(9'h00f, 8, 1'b0);
      peer.send(9'h0f0, 8, 1'b1);
      rd(`AURT_OFS_RX_STAT, 32'h94);
      rd(`AURT_OFS_RX_DATA, 32'h0f);
      rd(`AURT_OFS_RX_STAT, 32'h90);
      rd(`AURT_OFS_RX_DATA, 32'hf0);
      peer.send(9'h066, 8, 1'b0);
      wr(`AURT_OFS_RX_STAT, 32'h0);
      rd(`AURT_OFS_RX_STAT, 32'h0);
      wr(`AURT_OFS_RX_STAT, 32'h90);
      rd(`AURT_OFS_IRQ_CTL, 32'h0);
      $display("done: framing and flush");
   endtask
   task automatic t_modes;
      wr(`AURT_OFS_RX_STAT, 32'h80);
      wr(`AURT_OFS_BAUD_CTL, 32'h20);
      rx_inv <= 1'b1;
      wr(`AURT_OFS_RX_STAT, 32'h90);
      peer.send(9'h03c, 8, 1'b1);
      rd(`AURT_OFS_RX_STAT, 32'h90);
      rd(`AURT_OFS_RX_DATA, 32'h3c);
      wr(`AURT_OFS_RX_STAT, 32'h80);
      wr(`AURT_OFS_BAUD_CTL, 32'h0);
      rx_inv <= 1'b0;
      wr(`AURT_OFS_RX_STAT, 32'hd8);
      peer.send(9'h055, 9, 1'b1);
      rd(`AURT_OFS_IRQ_CTL, 32'h0);
      peer.send(9'h1a7, 9, 1'b1);
      rd(`AURT_OFS_RX_STAT, 32'hd9);
      rd(`AURT_OFS_RX_DATA, 32'ha7);
      wr(`AURT_OFS_RX_STAT, 32'h90);
      $display("done: polarity and address mode");
   endtask
   task automatic t_tx;
      logic [8:0] d;
      logic ok;
      wr(`AURT_OFS_TX_STAT, 32'h20);
      rd(`AURT_OFS_IRQ_CTL, 32'h20);
      check({31'h0, tx_oe}, 32'h1);
      wr(`AURT_OFS_IRQ_CTL, 32'h0b);
      check({31'h0, irq}, 32'h1);
      wr(`AURT_OFS_IRQ_CTL, 32'h0a);
      check({31'h0, irq}, 32'h0);
      wr(`AURT_OFS_TX_STAT, 32'h61);
      fork
         peer.catch(9, d, ok);
         wr(`AURT_OFS_TX_HOLD, 32'h5a);
      join
      check({22'h0, ok, d}, 32'h35a);
      wr(`AURT_OFS_TX_STAT, 32'h0);
      check({31'h0, tx_oe}, 32'h0);
      wr(`AURT_OFS_BAUD_CTL, 32'h10);
      wr(`AURT_OFS_TX_STAT, 32'h20);
      check({31'h0, tx_o}, 32'h0);
      wr(`AURT_OFS_TX_STAT, 32'h0);
      wr(`AURT_OFS_BAUD_CTL, 32'h0);
      $display("done: transmit");
   endtask
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      rx_inv = 1'b0;
      err_count = 0;
      checks = 0;
      cyc = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_enable();
      t_overrun();
      t_frame();
      t_modes();
      t_tx();
      summarize();
   end
endmodule // tb_top
